// *** rtl/pattern_next_data_enable.sv ***
// Next-data registers, per-bit enables and port output latches of a 16-bit pattern unit.
// Assumes compare match pulses and the register port run on sys_clk_in.
//
// The address-and-strobe port was chosen for this implementation.
`include "pattern_next_data_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - High next data: eight bits, read and write.
// - Selected match copies high data to port B.
// - Reset or hardware standby clears high data.
// - Shared trigger: whole byte at first address.
// - Shared trigger: second address reads ones, ignores writes.
// - Split trigger: group 3 first, group 2 second.
// - Split trigger: unused nibbles read ones, ignore writes.
// - Enabled low bit copies to port A latch.
// - Disabled low bit leaves port A unchanged.
// - Enabled high bit copies to port B latch.
// - Disabled high bit leaves port B unchanged.
// - Low enables cleared by reset and standby.
// - High enables cleared by reset and standby.
// - Low enable bit n gates bit n.
// - High enable bits 15..8 gate latch 7..0.
// - Select field picks timer channel 0, 1, 2.
// - Enabled latch bits are read-only to software.
module pattern_next_data_enable
    import pattern_next_data_pkg::*;
#(
    parameter int ADDR_W = `PND_ADDR_W
)
(
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    input  wire logic              hw_standby_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [2:0]        compare_match_in,
    output logic      [7:0]        reg_rdata_out,
    output logic      [7:0]        port_a_out,
    output logic      [7:0]        port_b_out
);

    // Elaboration-time refusal of an address bus too narrow for the map.
    if (ADDR_W < `PND_ADDR_W) begin : gen_addr_w_check
        $error("ADDR_W too narrow for the register map.");
    end

    // Address match against one printed byte address.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [`PND_ADDR_W-1:0] offs);
        addr_hit = (addr == ADDR_W'(offs));
    endfunction : addr_hit

    // Read view of a next-data register at its first or second address.
    function automatic logic [7:0] split_read(input logic [7:0] value,
                                              input logic       shared,
                                              input logic       second);
        logic [7:0] res;
        res = value;
        if (second) begin
            if (shared) begin
                res = `PND_RD_RESERVED;
            end else begin
                res = {`PND_NIB_RSV, value[`PND_LOWER_NIB]};
            end
        end else if (!shared) begin
            res = {value[`PND_UPPER_NIB], `PND_NIB_RSV};
        end
        split_read = res;
    endfunction : split_read

    // Write merge of a next-data register at its first or second address.
    function automatic logic [7:0] split_write(input logic [7:0] value,
                                               input logic [7:0] wdata,
                                               input logic       shared,
                                               input logic       second);
        logic [7:0] res;
        res = value;
        if (second) begin
            if (!shared) begin
                res = {value[`PND_UPPER_NIB], wdata[`PND_LOWER_NIB]};
            end
        end else if (shared) begin
            res = wdata;
        end else begin
            res = {wdata[`PND_UPPER_NIB], value[`PND_LOWER_NIB]};
        end
        split_write = res;
    endfunction : split_write

    // Two groups share a trigger when both pick the same timer channel.
    function automatic logic groups_share(input logic [1:0] sel_a,
                                          input logic [1:0] sel_b);
        groups_share = (chan_of(sel_a) == chan_of(sel_b));
    endfunction : groups_share

    logic                clear;
    logic                stby_meta_r;
    logic                stby_sync_r;
    logic [7:0]          high_next_data_r;
    logic [7:0]          high_next_data_nxt;
    logic [7:0]          low_next_data_r;
    logic [7:0]          low_next_data_nxt;
    logic [7:0]          low_enable_bits_r;
    logic [7:0]          high_enable_bits_r;
    trigger_select_reg_t trigger_select_reg_r;
    logic [7:0]          port_a_output_latch_r;
    logic [7:0]          port_a_output_latch_nxt;
    logic [7:0]          port_b_output_latch_r;
    logic [7:0]          port_b_output_latch_nxt;
    logic [7:0]          rdata_r;
    logic [7:0]          rdata_nxt;
    logic                high_shared;
    logic                low_shared;
    pattern_word_t       next_word;
    pattern_word_t       enable_word;
    pattern_word_t       load_word;
    logic [7:0]          trig_flat;

    logic hit_len;
    logic hit_hen;
    logic hit_trig;
    logic hit_hnd_a;
    logic hit_hnd_b;
    logic hit_lnd_a;
    logic hit_lnd_b;
    logic hit_pa;
    logic hit_pb;

    // Hardware standby comes from a pin; the first flip-flop may go metastable.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stby_meta_r <= 1'b0;
        end else begin
            stby_meta_r <= hw_standby_in;
        end
    end

    // Only this second flip-flop reads the first one.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stby_sync_r <= 1'b0;
        end else begin
            stby_sync_r <= stby_meta_r;
        end
    end

    // Hardware standby clears the same state as reset except the read data register rdata_r and the two standby flip-flops; software standby has no effect.
    assign clear = rst_in | stby_sync_r;

    assign hit_len   = addr_hit(reg_addr_in, `PND_ADDR_LEN);
    assign hit_hen   = addr_hit(reg_addr_in, `PND_ADDR_HEN);
    assign hit_trig  = addr_hit(reg_addr_in, `PND_ADDR_TRIG);
    assign hit_hnd_a = addr_hit(reg_addr_in, `PND_ADDR_HND_A);
    assign hit_hnd_b = addr_hit(reg_addr_in, `PND_ADDR_HND_B);
    assign hit_lnd_a = addr_hit(reg_addr_in, `PND_ADDR_LND_A);
    assign hit_lnd_b = addr_hit(reg_addr_in, `PND_ADDR_LND_B);
    assign hit_pa    = addr_hit(reg_addr_in, `PND_ADDR_PA);
    assign hit_pb    = addr_hit(reg_addr_in, `PND_ADDR_PB);

    // Sharing follows the decoded channel, so codes 10 and 11 count as equal.
    assign high_shared = groups_share(trigger_select_reg_r.group3, trigger_select_reg_r.group2);
    assign low_shared  = groups_share(trigger_select_reg_r.group1, trigger_select_reg_r.group0);

    assign next_word.high   = high_next_data_r;
    assign next_word.low    = low_next_data_r;
    assign enable_word.high = high_enable_bits_r;
    assign enable_word.low  = low_enable_bits_r;
    assign trig_flat        = trigger_select_reg_r;

    // One selector per four-bit group; group g covers pattern bits 4g+3 to 4g.
    for (genvar g = 0; g < 4; g++) begin : gen_group
        pattern_group_trigger u_trigger (
            .sel_in    (trig_flat[2*g +: 2]),
            .match_in  (compare_match_in),
            .enable_in (enable_word[4*g +: 4]),
            .load_out  (load_word[4*g +: 4])
        );
    end

    // High next data, with its address layout following the trigger sharing.
    always_comb begin
        high_next_data_nxt = high_next_data_r;
        if (reg_wr_in && hit_hnd_a) begin
            high_next_data_nxt = split_write(high_next_data_r, reg_wdata_in,
                                             high_shared, 1'b0);
        end else if (reg_wr_in && hit_hnd_b) begin
            high_next_data_nxt = split_write(high_next_data_r, reg_wdata_in,
                                             high_shared, 1'b1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            high_next_data_r <= `PND_RST_NEXT;
        end else begin
            high_next_data_r <= high_next_data_nxt;
        end
    end

    // Low next data, laid out the same way for groups 1 and 0.
    always_comb begin
        low_next_data_nxt = low_next_data_r;
        if (reg_wr_in && hit_lnd_a) begin
            low_next_data_nxt = split_write(low_next_data_r, reg_wdata_in,
                                            low_shared, 1'b0);
        end else if (reg_wr_in && hit_lnd_b) begin
            low_next_data_nxt = split_write(low_next_data_r, reg_wdata_in,
                                            low_shared, 1'b1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            low_next_data_r <= `PND_RST_NEXT;
        end else begin
            low_next_data_r <= low_next_data_nxt;
        end
    end

    // Low enable bits.
    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            low_enable_bits_r <= `PND_RST_EN;
        end else if (reg_wr_in && hit_len) begin
            low_enable_bits_r <= reg_wdata_in;
        end
    end

    // High enable bits.
    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            high_enable_bits_r <= `PND_RST_EN;
        end else if (reg_wr_in && hit_hen) begin
            high_enable_bits_r <= reg_wdata_in;
        end
    end

    // Trigger select fields of the four groups.
    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            trigger_select_reg_r <= `PND_RST_TRIG;
        end else if (reg_wr_in && hit_trig) begin
            trigger_select_reg_r <= reg_wdata_in;
        end
    end

    // Port A latch: software writes only the disabled bits, a match loads the enabled ones.
    always_comb begin
        port_a_output_latch_nxt = port_a_output_latch_r;
        if (reg_wr_in && hit_pa) begin
            port_a_output_latch_nxt = (port_a_output_latch_r & low_enable_bits_r) |
                                      (reg_wdata_in & ~low_enable_bits_r);
        end
        port_a_output_latch_nxt = (port_a_output_latch_nxt & ~load_word.low) |
                                  (next_word.low & load_word.low);
    end

    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            port_a_output_latch_r <= `PND_RST_LATCH;
        end else begin
            port_a_output_latch_r <= port_a_output_latch_nxt;
        end
    end

    // Port B latch: pattern bits 15 to 8 land in latch bits 7 to 0.
    always_comb begin
        port_b_output_latch_nxt = port_b_output_latch_r;
        if (reg_wr_in && hit_pb) begin
            port_b_output_latch_nxt = (port_b_output_latch_r & high_enable_bits_r) |
                                      (reg_wdata_in & ~high_enable_bits_r);
        end
        port_b_output_latch_nxt = (port_b_output_latch_nxt & ~load_word.high) |
                                  (next_word.high & load_word.high);
    end

    always_ff @(posedge sys_clk_in) begin
        if (clear) begin
            port_b_output_latch_r <= `PND_RST_LATCH;
        end else begin
            port_b_output_latch_r <= port_b_output_latch_nxt;
        end
    end

    // Read mux; data stand for the one cycle after the read strobe.
    always_comb begin
        rdata_nxt = `PND_RD_IDLE;
        if (reg_rd_in) begin
            rdata_nxt = `PND_RD_UNMAPPED;
            if (hit_hnd_a) begin
                rdata_nxt = split_read(high_next_data_r, high_shared, 1'b0);
            end else if (hit_hnd_b) begin
                rdata_nxt = split_read(high_next_data_r, high_shared, 1'b1);
            end else if (hit_lnd_a) begin
                rdata_nxt = split_read(low_next_data_r, low_shared, 1'b0);
            end else if (hit_lnd_b) begin
                rdata_nxt = split_read(low_next_data_r, low_shared, 1'b1);
            end else if (hit_len) begin
                rdata_nxt = low_enable_bits_r;
            end else if (hit_hen) begin
                rdata_nxt = high_enable_bits_r;
            end else if (hit_trig) begin
                rdata_nxt = trig_flat;
            end else if (hit_pa) begin
                rdata_nxt = port_a_output_latch_r;
            end else if (hit_pb) begin
                rdata_nxt = port_b_output_latch_r;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_r <= `PND_RD_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pins are only driven when software has set them to output elsewhere.
    assign port_a_out    = port_a_output_latch_r;
    assign port_b_out    = port_b_output_latch_r;
    assign reg_rdata_out = rdata_r;

endmodule : pattern_next_data_enable

`default_nettype wire

// *** rtl/pattern_next_data_defines.svh ***
// Address map, reset values and field positions of the pattern next-data block.
// Assumes a byte-wide register port with a 20-bit address.
`ifndef PATTERN_NEXT_DATA_DEFINES_SVH
`define PATTERN_NEXT_DATA_DEFINES_SVH

`define PND_ADDR_W      20
`define PND_ADDR_LEN    20'hFFFA0
`define PND_ADDR_HEN    20'hFFFA1
`define PND_ADDR_TRIG   20'hFFFA2
`define PND_ADDR_HND_A  20'hFFFA4
`define PND_ADDR_LND_A  20'hFFFA5
`define PND_ADDR_HND_B  20'hFFFA6
`define PND_ADDR_LND_B  20'hFFFA7
`define PND_ADDR_PA     20'hFFFA8
`define PND_ADDR_PB     20'hFFFA9

`define PND_RST_NEXT    8'h00
`define PND_RST_EN      8'h00
`define PND_RST_TRIG    8'hFF
`define PND_RST_LATCH   8'h00

`define PND_RD_RESERVED 8'hFF
`define PND_RD_UNMAPPED 8'h00
`define PND_RD_IDLE     8'h00
`define PND_NIB_RSV     4'hF

`define PND_UPPER_NIB   7:4
`define PND_LOWER_NIB   3:0

`endif

// *** rtl/pattern_next_data_pkg.sv ***
// Types shared by the pattern next-data block and its trigger selector.
// Assumes nothing of its surroundings.
package pattern_next_data_pkg;

    typedef enum logic [1:0] {
        CHAN0 = 2'h0,
        CHAN1 = 2'h1,
        CHAN2 = 2'h2
    } timer_chan_t;

    typedef struct packed {
        logic [1:0] group3;
        logic [1:0] group2;
        logic [1:0] group1;
        logic [1:0] group0;
    } trigger_select_reg_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } pattern_word_t;

    // Maps a two-bit select field to its timer channel; both upper codes mean channel 2.
    function automatic timer_chan_t chan_of(input logic [1:0] sel);
        chan_of = sel[1] ? CHAN2 : (sel[0] ? CHAN1 : CHAN0);
    endfunction : chan_of

endpackage : pattern_next_data_pkg

// *** rtl/pattern_group_trigger.sv ***
// Trigger selector of one four-bit pattern group.
// Assumes compare match pulses one cycle long on the system clock.
`timescale 1ns/1ps
`default_nettype none

module pattern_group_trigger
    import pattern_next_data_pkg::*;
(
    input  wire logic [1:0] sel_in,
    input  wire logic [2:0] match_in,
    input  wire logic [3:0] enable_in,
    output logic      [3:0] load_out
);

    logic fire;

    always_comb begin
        unique case (chan_of(sel_in))
            CHAN0:   fire = match_in[0];
            CHAN1:   fire = match_in[1];
            CHAN2:   fire = match_in[2];
            default: fire = 1'b0;
        endcase
    end

    // Only enabled bits of the group take a transfer.
    assign load_out = enable_in & {4{fire}};

endmodule : pattern_group_trigger

`default_nettype wire

// *** dv/pattern_next_data_assertions.sv ***
// Port checker of the pattern next-data block.
// Assumes one clock domain and the block's defines header.
`include "pattern_next_data_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pattern_next_data_checker
    import pattern_next_data_pkg::*;
#(
    parameter int ADDR_W = `PND_ADDR_W
)
(
    input wire logic              sys_clk_in,
    input wire logic              rst_in,
    input wire logic              hw_standby_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0]        reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [2:0]        compare_match_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic [7:0]        port_a_out,
    input wire logic [7:0]        port_b_out
);
    logic [7:0] en_a_r;
    logic [7:0] en_b_r;
    logic       stby_d1_r;
    logic       stby_d2_r;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // Standby pin as seen two flip-flops later, when it clears the block.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stby_d1_r <= 1'b0;
            stby_d2_r <= 1'b0;
        end else begin
            stby_d1_r <= hw_standby_in;
            stby_d2_r <= stby_d1_r;
        end
    end
    // Mirrors the enable registers as software writes them.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || stby_d2_r) begin
            en_a_r <= `PND_RST_EN;
            en_b_r <= `PND_RST_EN;
        end else if (reg_wr_in && reg_addr_in == `PND_ADDR_LEN) begin
            en_a_r <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `PND_ADDR_HEN) begin
            en_b_r <= reg_wdata_in;
        end
    end
    AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == `PND_RD_IDLE)
        else $error("read data not idle");
    AST_SECOND_RSV: assert property (reg_rd_in && reg_addr_in == `PND_ADDR_HND_B
        |=> reg_rdata_out[7:4] == `PND_NIB_RSV) else $error("reserved nibble not ones");
    AST_STBY_LEN: assert property (stby_d2_r ##1 (reg_rd_in && reg_addr_in == `PND_ADDR_LEN)
        |=> reg_rdata_out == `PND_RST_EN) else $error("low enables not cleared");
    AST_STBY_HEN: assert property (stby_d2_r ##1 (reg_rd_in && reg_addr_in == `PND_ADDR_HEN)
        |=> reg_rdata_out == `PND_RST_EN) else $error("high enables not cleared");
    AST_STBY_HND: assert property (stby_d2_r ##1 (reg_rd_in && reg_addr_in == `PND_ADDR_HND_A)
        |=> reg_rdata_out == `PND_RST_NEXT) else $error("high next data not cleared");
    AST_PA_KEEP: assert property (compare_match_in == 3'h0 && !stby_d2_r
        && !(reg_wr_in && reg_addr_in == `PND_ADDR_PA) |=> $stable(port_a_out)) else $error("port a moved");
    AST_PB_KEEP: assert property (compare_match_in == 3'h0 && !stby_d2_r
        && !(reg_wr_in && reg_addr_in == `PND_ADDR_PB) |=> $stable(port_b_out)) else $error("port b moved");
    AST_PA_DIS: assert property (compare_match_in != 3'h0 && !reg_wr_in && !stby_d2_r
        |=> ((port_a_out ^ $past(port_a_out)) & ~$past(en_a_r)) == 8'h00) else $error("disabled a bit moved");
    AST_PB_DIS: assert property (compare_match_in != 3'h0 && !reg_wr_in && !stby_d2_r
        |=> ((port_b_out ^ $past(port_b_out)) & ~$past(en_b_r)) == 8'h00) else $error("disabled b bit moved");
    AST_PA_RO: assert property (reg_wr_in && reg_addr_in == `PND_ADDR_PA && compare_match_in == 3'h0
        && !stby_d2_r |=> port_a_out == (($past(port_a_out) & $past(en_a_r))
        | ($past(reg_wdata_in) & ~$past(en_a_r)))) else $error("enabled latch bit written");
    AST_PB_RO: assert property (reg_wr_in && reg_addr_in == `PND_ADDR_PB && compare_match_in == 3'h0
        && !stby_d2_r |=> port_b_out == (($past(port_b_out) & $past(en_b_r))
        | ($past(reg_wdata_in) & ~$past(en_b_r)))) else $error("enabled b latch bit written");
endmodule : pattern_next_data_checker
bind pattern_next_data_enable pattern_next_data_checker #(.ADDR_W(ADDR_W)) chk_u (
    .sys_clk_in, .rst_in, .hw_standby_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .compare_match_in, .reg_rdata_out, .port_a_out, .port_b_out);
`default_nettype wire

// *** dv/timer_match_model.sv ***
// Timer side: compare match pulses toward the block.
// Assumes pulse is called right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module timer_match_model (
    input  wire logic       sys_clk_in,
    output var  logic [2:0] match_out
);
    // Every pattern pin is taken as set to output direction.
    initial match_out = 3'h0;
    // One-cycle pulse of one channel; ch 0 to 2 picks the channel, ch 3 drives no pulse.
    task automatic pulse(input int unsigned ch);
        match_out <= 3'h1 << ch;
        @(posedge sys_clk_in);
        match_out <= 3'h0;
    endtask : pulse
endmodule : timer_match_model
`default_nettype wire

// *** dv/tb.sv ***
// Bench of the pattern next-data block.
// Assumes the checker bind and the timer model.
`include "pattern_next_data_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        stby    = 1'b0;
    logic [19:0] addr    = 20'h00000;
    logic [7:0]  wdata   = 8'h00;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [2:0]  cm;
    logic [7:0]  rdata;
    logic [7:0]  pa;
    logic [7:0]  pb;
    int          error_cnt   = 0;
    int          checks_done = 0;
    always #25 sys_clk = ~sys_clk;
    pattern_next_data_enable dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .hw_standby_in(stby),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .compare_match_in(cm), .reg_rdata_out(rdata), .port_a_out(pa), .port_b_out(pb));
    timer_match_model tm_u (.sys_clk_in(sys_clk), .match_out(cm));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #5;
        chk($sformatf("reg %h", a), rdata, exp);
    endtask : rd_chk
    task automatic fire(input int unsigned ch);
        @(posedge sys_clk);
        tm_u.pulse(ch);
        #5;
    endtask : fire
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`PND_ADDR_LEN, 8'h00);
        rd_chk(`PND_ADDR_HEN, 8'h00);
        rd_chk(`PND_ADDR_HND_A, 8'h00);
        rd_chk(`PND_ADDR_HND_B, 8'hFF);
        rd_chk(20'hFFFA3, 8'h00);
        $display("test reset_values done");
        wr_reg(`PND_ADDR_HND_A, 8'hA5);
        wr_reg(`PND_ADDR_HND_B, 8'h12);
        rd_chk(`PND_ADDR_HND_A, 8'hA5);
        rd_chk(`PND_ADDR_HND_B, 8'hFF);
        wr_reg(`PND_ADDR_HEN, 8'hF0);
        fire(0);
        chk("port_b", pb, 8'h00);
        fire(2);
        chk("port_b", pb, 8'hA0);
        wr_reg(`PND_ADDR_HEN, 8'hFF);
        fire(2);
        chk("port_b", pb, 8'hA5);
        $display("test shared_layout done");
        wr_reg(`PND_ADDR_TRIG, 8'h1B);
        rd_chk(`PND_ADDR_HND_A, 8'hAF);
        rd_chk(`PND_ADDR_HND_B, 8'hF5);
        wr_reg(`PND_ADDR_HND_A, 8'h3C);
        wr_reg(`PND_ADDR_HND_B, 8'hC7);
        rd_chk(`PND_ADDR_HND_A, 8'h3F);
        rd_chk(`PND_ADDR_HND_B, 8'hF7);
        fire(1);
        chk("port_b", pb, 8'hA7);
        fire(0);
        chk("port_b", pb, 8'h37);
        wr_reg(`PND_ADDR_LND_A, 8'h96);
        wr_reg(`PND_ADDR_LEN, 8'h0F);
        fire(2);
        chk("port_a", pa, 8'h06);
        wr_reg(`PND_ADDR_PA, 8'hF0);
        rd_chk(`PND_ADDR_PA, 8'hF6);
        wr_reg(`PND_ADDR_HEN, 8'h0F);
        wr_reg(`PND_ADDR_PB, 8'hC0);
        rd_chk(`PND_ADDR_PB, 8'hC7);
        chk("port_b", pb, 8'hC7);
        rd_chk(`PND_ADDR_TRIG, 8'h1B);
        wr_reg(`PND_ADDR_TRIG, 8'hE4);
        rd_chk(`PND_ADDR_HND_A, 8'h37);
        rd_chk(`PND_ADDR_HND_B, 8'hFF);
        $display("test split_layout done");
        @(posedge sys_clk);
        stby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk(`PND_ADDR_LEN, 8'h00);
        rd_chk(`PND_ADDR_HEN, 8'h00);
        rd_chk(`PND_ADDR_HND_A, 8'h00);
        @(posedge sys_clk);
        stby <= 1'b0;
        $display("test standby done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
